// File: logic/spidf_port.sv
// Purpose: serial port, master or slave, fed by one dma channel
// Assumes: clk at 200 MHz; link_sck is the far master's serial clock
// Notes: see summary below
// ==============================================================
// Summary of operation
// - in slave mode enabling, or a polarity change while enabled, raises a false receive ready flag.
// - in slave mode the disable command is ignored and the port keeps running.
// - with select hold set and fault detection on the port never starts a transfer.
// - disabling the port leaves the transmit empty flag as it was.
// - writes to the transmit register while disabled are dropped and leave the flag as it was.
// - a running dma channel keeps writing to a disabled port until its count ends.
// - a transfer error stalls the dma handshake and no further words move until a fresh enable of the port.
module spidf_port #(
    parameter int HALF_CYCLES = spidf_pkg::HALF_PERIOD_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // software control and status
    input wire spidf_pkg::spidf_cfg_t cfg,
    input wire spidf_pkg::spidf_cmd_t cmd,
    input wire logic tx_write,
    input wire logic [spidf_pkg::WORD_BITS-1:0] tx_data,
    output logic enabled,
    output logic receive_ready_flag,
    output logic transmit_empty_flag,
    output logic mode_fault,
    output logic busy,
    output logic [spidf_pkg::WORD_BITS-1:0] receive_holding_register,
    // dma channel
    input wire logic dma_enable,
    input wire logic dma_count_load,
    input wire logic [spidf_pkg::COUNT_BITS-1:0] dma_count_value,
    input wire logic mem_valid,
    input wire logic mem_error,
    input wire logic [spidf_pkg::WORD_BITS-1:0] mem_data,
    output logic mem_ready,
    output logic dma_stalled,
    output logic [spidf_pkg::COUNT_BITS-1:0] dma_remaining,
    // serial pins
    input wire logic link_sck,
    input wire logic select_in_n,
    input wire logic miso_in,
    input wire logic mosi_in,
    output logic sck_out,
    output logic sck_oe,
    output logic mosi_out,
    output logic mosi_oe,
    output logic miso_out,
    output logic miso_oe,
    output logic select0_out_n
);
    localparam int W = spidf_pkg::WORD_BITS;
    localparam int DW = $clog2(HALF_CYCLES + 1);
    localparam logic [DW-1:0] DIV_LAST = DW'(HALF_CYCLES - 1);
    localparam logic [4:0] EDGE_LAST = 5'(spidf_pkg::EDGE_COUNT - 1);

    // elaboration check: the divider needs at least one cycle
    if (HALF_CYCLES < 1) begin : g_half_check
        $error("spidf_port: HALF_CYCLES must be at least 1");
    end

    spidf_pkg::spidf_state_t state;
    logic enabled_d, polarity_d, enable_rise, slave_glitch;
    logic [2:0] sy1, sy2, sy3, stable;
    logic toggle_seen, slave_done, master_done, start, start_block;
    logic dma_write, dma_fault, any_write;
    logic [W-1:0] tx_hold, tx_shift, rx_shift, slave_rx, write_data;
    logic [DW-1:0] div;
    logic [4:0] edge_n;
    logic slave_toggle, slave_miso, sample_edge, fault_seen;

    // ==========================================================
    // enable state
    assign enable_rise = enabled & ~enabled_d;

    // slave mode keeps running through a disable command
    always_ff @(posedge clk) begin
        if (reset || cmd.software_reset_bit) begin
            enabled <= 1'b0;
        end else if (fault_seen) begin
            enabled <= 1'b0;
        end else if (cmd.enable_cmd) begin
            enabled <= 1'b1;
        end else if (cmd.disable_cmd && cfg.master_mode) begin
            enabled <= 1'b0;
        end
    end

    // edge history for enable and polarity
    always_ff @(posedge clk) begin
        if (reset) begin
            enabled_d <= 1'b0;
            polarity_d <= 1'b0;
        end else begin
            enabled_d <= enabled;
            polarity_d <= cfg.clock_polarity;
        end
    end

    // ==========================================================
    // pin and toggle synchronisers: a change counts once stages 2, 3 agree
    always_ff @(posedge clk) begin
        if (reset) begin
            // toggle resets to 0 and select idles high
            sy1 <= 3'h3;
            sy2 <= 3'h3;
            sy3 <= 3'h3;
            stable <= 3'h3;
        end else begin
            sy1 <= {slave_toggle, select_in_n, miso_in};
            sy2 <= sy1;
            sy3 <= sy2;
            for (int i = 0; i < 3; i++) begin
                if (sy2[i] == sy3[i]) begin
                    stable[i] <= sy3[i];
                end
            end
        end
    end

    // seen copy resets to the toggle's own reset level, so an early
    // enable after reset never raises slave_done for a word that was not received
    always_ff @(posedge clk) begin
        if (reset) begin
            toggle_seen <= 1'b0;
        end else begin
            toggle_seen <= stable[2];
        end
    end
    assign slave_done = (stable[2] != toggle_seen) & enabled
                      & ~cfg.master_mode;

    // ==========================================================
    // slave shifter on the far master's clock
    spidf_slave_shift #(.WIDTH(W)) i_spidf_slave_shift (
        .link_clk(link_sck),
        .link_clear(reset),
        .select_n(select_in_n),
        .mosi_in(mosi_in),
        .miso_out(slave_miso),
        .tx_word(tx_hold),
        .rx_word(slave_rx),
        .word_toggle(slave_toggle)
    );

    // ==========================================================
    // mode fault: another master pulls our select low
    assign fault_seen = enabled & cfg.master_mode
                      & ~cfg.fault_detect_disable & ~stable[1];

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_fault <= 1'b0;
        end else if (fault_seen) begin
            mode_fault <= 1'b1;
        end else if (cmd.software_reset_bit) begin
            mode_fault <= 1'b0;
        end
    end

    // ==========================================================
    // receive path; the false flag mirrors the slave enable hazard
    assign slave_glitch = ~cfg.master_mode & (enable_rise
                        | (enabled & (cfg.clock_polarity != polarity_d)));

    always_ff @(posedge clk) begin
        if (reset || cmd.software_reset_bit) begin
            receive_ready_flag <= 1'b0;
        end else if (master_done || slave_done || slave_glitch) begin
            receive_ready_flag <= 1'b1;
        end else if (cmd.receive_read) begin
            receive_ready_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            receive_holding_register <= spidf_pkg::DATA_RESET;
        end else if (master_done) begin
            receive_holding_register <= rx_shift;
        end else if (slave_done) begin
            receive_holding_register <= slave_rx;
        end
    end

    // ==========================================================
    // dma channel: moves a word whenever the transmit register is empty
    assign dma_write = dma_enable & ~dma_stalled & (dma_remaining != '0)
                     & transmit_empty_flag & mem_valid & ~mem_error;
    assign dma_fault = dma_enable & ~dma_stalled & (dma_remaining != '0)
                     & transmit_empty_flag & mem_valid & mem_error;
    assign mem_ready = dma_write;

    always_ff @(posedge clk) begin
        if (reset) begin
            dma_remaining <= spidf_pkg::COUNT_RESET;
        end else if (dma_count_load) begin
            dma_remaining <= dma_count_value;
        end else if (dma_write) begin
            dma_remaining <= dma_remaining - 1'b1;
        end
    end

    // only a fresh enable of the port releases the stalled handshake
    always_ff @(posedge clk) begin
        if (reset) begin
            dma_stalled <= 1'b0;
        end else if (dma_fault) begin
            dma_stalled <= 1'b1;
        end else if (enable_rise) begin
            dma_stalled <= 1'b0;
        end
    end

    // ==========================================================
    // transmit register; software wins if both write in one cycle
    assign any_write = tx_write | dma_write;
    assign write_data = tx_write ? tx_data : mem_data;

    always_ff @(posedge clk) begin
        if (reset) begin
            tx_hold <= spidf_pkg::DATA_RESET;
        end else if (any_write && enabled) begin
            tx_hold <= write_data;
        end
    end

    // disabling touches nothing here, so the flag keeps its value
    always_ff @(posedge clk) begin
        if (reset || cmd.software_reset_bit) begin
            transmit_empty_flag <= spidf_pkg::TX_EMPTY_RESET;
        end else if (any_write && enabled) begin
            transmit_empty_flag <= 1'b0;
        end else if (start || slave_done) begin
            transmit_empty_flag <= 1'b1;
        end
    end

    // ==========================================================
    // master engine; held select with fault detection never starts
    assign start_block = cfg.select_hold_after_transfer
                       & ~cfg.fault_detect_disable;
    assign start = (state == spidf_pkg::ST_IDLE) & enabled & cfg.master_mode
                 & ~transmit_empty_flag & ~start_block & ~fault_seen;
    assign sample_edge = (edge_n[0] == cfg.clock_phase);
    assign busy = (state == spidf_pkg::ST_SHIFT);

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= spidf_pkg::ST_IDLE;
            div <= '0;
            edge_n <= '0;
            master_done <= 1'b0;
            sck_out <= 1'b0;
            tx_shift <= spidf_pkg::DATA_RESET;
            rx_shift <= spidf_pkg::DATA_RESET;
        end else begin
            master_done <= 1'b0;
            unique case (state)
                spidf_pkg::ST_IDLE: begin
                    sck_out <= cfg.clock_polarity;
                    div <= '0;
                    edge_n <= '0;
                    if (start) begin
                        tx_shift <= tx_hold;
                        state <= spidf_pkg::ST_SHIFT;
                    end
                end
                spidf_pkg::ST_SHIFT: begin
                    if (div != DIV_LAST) begin
                        div <= div + 1'b1;
                    end else begin
                        div <= '0;
                        sck_out <= ~sck_out;
                        edge_n <= edge_n + 1'b1;
                        if (sample_edge) begin
                            rx_shift <= {rx_shift[W-2:0], stable[0]};
                        end else if (edge_n != '0) begin
                            tx_shift <= {tx_shift[W-2:0], 1'b0};
                        end
                        if (edge_n == EDGE_LAST) begin
                            master_done <= 1'b1;
                            state <= spidf_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= spidf_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // chip select 0 may stay low after a word when held by software
    always_ff @(posedge clk) begin
        if (reset || !enabled) begin
            select0_out_n <= 1'b1;
        end else if (start) begin
            select0_out_n <= 1'b0;
        end else if (master_done && !cfg.select_hold_after_transfer) begin
            select0_out_n <= 1'b1;
        end
    end

    // pin drive: master owns clock and mosi, slave owns miso in a frame
    assign mosi_out = tx_shift[W-1];
    assign miso_out = slave_miso;
    assign sck_oe = enabled & cfg.master_mode;
    assign mosi_oe = enabled & cfg.master_mode;
    assign miso_oe = enabled & ~cfg.master_mode & ~stable[1];

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_glitch_on_enable: assert property (
        enable_rise && !cfg.master_mode && !cmd.software_reset_bit
        |=> receive_ready_flag)
        else $error("slave enable did not raise receive ready");

    a_slave_keeps_on: assert property (
        enabled && !cfg.master_mode && cmd.disable_cmd
        && !cmd.software_reset_bit |=> enabled)
        else $error("slave port obeyed a disable command");

    a_hold_fault_hang: assert property (
        cfg.select_hold_after_transfer && !cfg.fault_detect_disable
        && state == spidf_pkg::ST_IDLE |=> !busy)
        else $error("transfer started with held select and fault detect");

    a_disable_keeps_empty: assert property (
        $fell(enabled) && !$past(cmd.software_reset_bit)
        |-> transmit_empty_flag == $past(transmit_empty_flag)
            || $past(start))
        else $error("disabling changed the transmit empty flag");

    a_dropped_write: assert property (
        !enabled && any_write && !cmd.software_reset_bit
        |=> $stable(transmit_empty_flag) && $stable(tx_hold))
        else $error("write while disabled was not dropped");

    a_dma_keeps_writing: assert property (
        !enabled && dma_enable && !dma_stalled && transmit_empty_flag
        && dma_remaining != '0 && mem_valid && !mem_error
        && !dma_count_load
        |-> mem_ready ##1 dma_remaining == $past(dma_remaining) - 1'b1)
        else $error("dma stopped writing to a disabled port");

    a_error_stalls: assert property (
        dma_fault ##1 !enable_rise |-> !mem_ready ##1 dma_stalled)
        else $error("dma moved a word after a transfer error");

endmodule : spidf_port

// File: logic/spidf_pkg.sv
// Purpose: shared constants and carriers of the serial port with dma feed
// Assumes: one word of WORD_BITS bits per frame, msb first
// Notes: used by spidf_port and spidf_slave_shift
package spidf_pkg;

    // ==========================================================
    // sizes and counts
    localparam int WORD_BITS = 8;
    localparam int EDGE_COUNT = 2 * WORD_BITS;
    localparam int HALF_PERIOD_CYCLES = 4;
    localparam int COUNT_BITS = 16;

    // ==========================================================
    // values after reset
    localparam logic [WORD_BITS-1:0] DATA_RESET = 8'h00;
    localparam logic [COUNT_BITS-1:0] COUNT_RESET = 16'h0000;
    localparam logic TX_EMPTY_RESET = 1'b1;

    // ==========================================================
    // configuration levels held by software
    typedef struct packed {
        logic master_mode;
        logic clock_polarity;
        logic clock_phase;
        logic select_hold_after_transfer;
        logic fault_detect_disable;
    } spidf_cfg_t;

    // one-cycle command strobes from software
    typedef struct packed {
        logic enable_cmd;
        logic disable_cmd;
        logic software_reset_bit;
        logic receive_read;
    } spidf_cmd_t;

    // master shift engine
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SHIFT = 2'b10
    } spidf_state_t;

endpackage : spidf_pkg

// File: logic/spidf_slave_shift.sv
// Purpose: slave shifter clocked by the serial clock of the far master
// Assumes: data sampled on the rising serial clock edge, msb first
// Notes: the frame select resets the bit count, so no edge is needed
//        outside a frame; each finished word flips word_toggle
module spidf_slave_shift #(
    parameter int WIDTH = spidf_pkg::WORD_BITS
) (
    // link side
    input wire logic link_clk,
    input wire logic link_clear,
    input wire logic select_n,
    input wire logic mosi_in,
    output logic miso_out,
    // word side
    input wire logic [WIDTH-1:0] tx_word,
    output logic [WIDTH-1:0] rx_word,
    output logic word_toggle
);
    localparam int CW = $clog2(WIDTH);
    localparam logic [CW-1:0] LAST = CW'(WIDTH - 1);

    logic [CW-1:0] bit_count;
    logic [WIDTH-1:0] rx_shift;
    logic [WIDTH-1:0] tx_shift;

    // elaboration check: the shifters need at least two bits
    if (WIDTH < 2) begin : g_width_check
        $error("spidf_slave_shift: WIDTH must be at least 2");
    end

    // ==========================================================
    // bit count, cleared whenever the frame select is released
    always_ff @(posedge link_clk or posedge select_n) begin
        if (select_n) begin
            bit_count <= '0;
        end else if (bit_count == LAST) begin
            bit_count <= '0;
        end else begin
            bit_count <= bit_count + 1'b1;
        end
    end

    // receive shift; the word is held until the next word ends, long
    // enough for the other domain to take it after the toggle syncs
    always_ff @(posedge link_clk or posedge link_clear) begin
        if (link_clear) begin
            rx_shift <= '0;
            rx_word <= '0;
            word_toggle <= 1'b0;
        end else begin
            rx_shift <= {rx_shift[WIDTH-2:0], mosi_in};
            if (bit_count == LAST) begin
                rx_word <= {rx_shift[WIDTH-2:0], mosi_in};
                word_toggle <= ~word_toggle;
            end
        end
    end

    // transmit shift; tx_word is quasi-static while a frame runs
    always_ff @(posedge link_clk or posedge link_clear) begin
        if (link_clear) begin
            tx_shift <= '0;
        end else if (bit_count == '0) begin
            tx_shift <= {tx_word[WIDTH-2:0], 1'b0};
        end else begin
            tx_shift <= {tx_shift[WIDTH-2:0], 1'b0};
        end
    end

    // first bit must be on the line before the first rising edge
    assign miso_out = (bit_count == '0) ? tx_word[WIDTH-1]
                                        : tx_shift[WIDTH-1];

endmodule : spidf_slave_shift

// File: test/spidf_peer.sv
// Purpose: far side of the serial port, a master for slave mode and a
//          plain answering slave for master mode
// Assumes: link clock of 64 ns that runs only inside a frame
// Notes: released lines never hold their last value
module spidf_peer (
    // pins toward the port
    output logic link_sck,
    output logic select_in_n,
    output logic mosi_in,
    output logic miso_in,
    // pins from the port
    input wire logic sck_out,
    input wire logic select0_out_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] reply = 8'ha5;

    // ==========================================================
    // idle levels: clock parked low, select released
    initial begin
        link_sck = 1'b0;
        select_in_n = 1'b1;
        mosi_in = 1'b0;
        miso_in = 1'b0;
    end

    // answering slave: a deselected line flips so it never looks held
    always @(sck_out or select0_out_n) begin
        if (select0_out_n) begin
            miso_in = ~miso_in;
        end else begin
            miso_in = reply[7];
            reply = {reply[6:0], ~reply[7]};
        end
    end

    // one word msb first; clock only toggles inside the frame
    task send(input logic [7:0] w);
        int b;
        #7;
        select_in_n = 1'b0;
        for (b = 7; b >= 0; b--) begin
            mosi_in = w[b];
            #32 link_sck = 1'b1;
            #32 link_sck = 1'b0;
        end
        #16 select_in_n = 1'b1;
        mosi_in = ~mosi_in;
    endtask : send
endmodule : spidf_peer

// File: test/test_spi_port_with_dma_feed.sv
// Purpose: self-checking bench of the serial port with dma feed
// Assumes: clk 5 ns, synchronous reset held 4 cycles
// Notes: random words from an lfsr seeded with a fixed value
module test_spi_port_with_dma_feed;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic reset = 1'b1;
    spidf_pkg::spidf_cfg_t cfg = '0;
    spidf_pkg::spidf_cmd_t cmd = '0;
    logic tx_write = 1'b0;
    logic [7:0] tx_data = 8'h00;
    // a single dma channel, so no identifier is ever shared
    logic dma_enable = 1'b0;
    logic dma_count_load = 1'b0;
    logic [15:0] dma_count_value = 16'h0000;
    logic mem_valid = 1'b0;
    logic mem_error = 1'b0;
    logic [7:0] mem_data = 8'h00;
    logic enabled, receive_ready_flag, transmit_empty_flag, mode_fault, busy;
    logic [7:0] receive_holding_register;
    logic mem_ready, dma_stalled;
    logic [15:0] dma_remaining;
    logic link_sck, select_in_n, miso_in, mosi_in, sck_out, select0_out_n;
    logic sck_oe, mosi_oe, miso_oe, mosi_out;
    logic [7:0] mosi_seen = 8'h00;
    int err_total = 0;
    int compares = 0;
    logic [31:0] rnd = 32'd72143;
    logic [7:0] word;

    // ==========================================================
    // clock, device and far side
    always #2.5 clk = ~clk;

    spidf_port #(.HALF_CYCLES(4)) i_spidf_port (
        .clk(clk), .reset(reset), .cfg(cfg), .cmd(cmd),
        .tx_write(tx_write), .tx_data(tx_data), .enabled(enabled),
        .receive_ready_flag(receive_ready_flag),
        .transmit_empty_flag(transmit_empty_flag),
        .mode_fault(mode_fault), .busy(busy),
        .receive_holding_register(receive_holding_register),
        .dma_enable(dma_enable), .dma_count_load(dma_count_load),
        .dma_count_value(dma_count_value), .mem_valid(mem_valid),
        .mem_error(mem_error), .mem_data(mem_data),
        .mem_ready(mem_ready), .dma_stalled(dma_stalled),
        .dma_remaining(dma_remaining), .link_sck(link_sck),
        .select_in_n(select_in_n), .miso_in(miso_in), .mosi_in(mosi_in),
        .sck_out(sck_out), .sck_oe(sck_oe), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_out(), .miso_oe(miso_oe),
        .select0_out_n(select0_out_n));

    // master output bits, taken on the rising serial clock (phase 0)
    always @(posedge sck_out) begin
        mosi_seen <= {mosi_seen[6:0], mosi_out};
    end

    spidf_peer i_spidf_peer (
        .link_sck(link_sck), .select_in_n(select_in_n),
        .mosi_in(mosi_in), .miso_in(miso_in),
        .sck_out(sck_out), .select0_out_n(select0_out_n));

    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction : lfsr_next

    task check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // one-cycle command pulse, driven on the rising edge
    task pulse(input spidf_pkg::spidf_cmd_t c);
        cyc(1);
        cmd <= c;
        cyc(1);
        cmd <= '0;
    endtask : pulse

    // bounded wait; a timeout is one mismatch
    task wait_on(input int sel, input logic lvl);
        logic v;
        for (int k = 0; k < 500; k++) begin
            @(posedge clk);
            #1;
            case (sel)
                0: v = busy;
                1: v = receive_ready_flag;
                default: v = (dma_remaining == 16'h0000);
            endcase
            if (v === lvl) return;
        end
        check(16'h0000, 16'h0001);
    endtask : wait_on

    task results();
        if (err_total == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    // watchdog well beyond the expected run of under a thousand cycles
    initial begin
        #200000;
        err_total++;
        results();
    end

    // ==========================================================
    // main sequence
    initial begin
        cyc(4);
        reset <= 1'b0;
        cyc(4);
        #1;
        check(transmit_empty_flag, 1'b1);
        check({enabled, receive_ready_flag, dma_stalled}, 3'b000);
        // slave: enable raises a false ready flag
        pulse('{enable_cmd: 1'b1, default: 1'b0});
        cyc(2);
        #1;
        check(receive_ready_flag, 1'b1);
        cyc(1);
        cfg.clock_polarity <= 1'b1;
        cyc(1);
        cfg.clock_polarity <= 1'b0;
        cyc(3);
        pulse('{receive_read: 1'b1, default: 1'b0});
        cyc(2);
        #1;
        check(receive_ready_flag, 1'b0);
        pulse('{disable_cmd: 1'b1, default: 1'b0});
        cyc(2);
        #1;
        check(enabled, 1'b1);
        for (int n = 0; n < 4; n++) begin
            rnd = lfsr_next(rnd);
            word = (n == 0) ? 8'h80 : rnd[7:0];
            i_spidf_peer.send(word);
            check({sck_oe, mosi_oe, miso_oe}, 3'b001);
            wait_on(1, 1'b1);
            check(receive_holding_register, word);
            pulse('{receive_read: 1'b1, default: 1'b0});
        end
        pulse('{software_reset_bit: 1'b1, default: 1'b0});
        cyc(1);
        #1;
        check({enabled, receive_ready_flag}, 2'b00);
        // disabled port drops software writes
        cyc(1);
        tx_write <= 1'b1;
        tx_data <= rnd[15:8];
        cyc(1);
        tx_write <= 1'b0;
        cyc(3);
        #1;
        check(transmit_empty_flag, 1'b1);
        // master with select hold and fault detection on: no start
        cyc(1);
        cfg <= '{master_mode: 1'b1, select_hold_after_transfer: 1'b1,
                 default: 1'b0};
        pulse('{enable_cmd: 1'b1, default: 1'b0});
        tx_write <= 1'b1;
        cyc(1);
        tx_write <= 1'b0;
        cyc(40);
        #1;
        check({busy, transmit_empty_flag}, 2'b00);
        pulse('{disable_cmd: 1'b1, default: 1'b0});
        cyc(2);
        #1;
        check({enabled, transmit_empty_flag}, 2'b00);
        cyc(1);
        cfg.fault_detect_disable <= 1'b1;
        pulse('{enable_cmd: 1'b1, default: 1'b0});
        wait_on(0, 1'b1);
        check({sck_oe, mosi_oe, miso_oe}, 3'b110);
        wait_on(0, 1'b0);
        wait_on(1, 1'b1);
        check({select0_out_n, mode_fault}, 2'b00);
        check(mosi_seen, tx_data);
        pulse('{software_reset_bit: 1'b1, default: 1'b0});
        // dma into a disabled port: words move and are lost
        cyc(1);
        cfg.select_hold_after_transfer <= 1'b0;
        dma_count_load <= 1'b1;
        dma_count_value <= 16'h0005;
        mem_data <= rnd[23:16];
        cyc(1);
        dma_count_load <= 1'b0;
        dma_enable <= 1'b1;
        mem_valid <= 1'b1;
        #1;
        check(mem_ready, 1'b1);
        cyc(12);
        #1;
        check(dma_remaining, 16'h0000);
        check(transmit_empty_flag, 1'b1);
        // transfer error stalls the handshake
        cyc(1);
        dma_enable <= 1'b0;
        dma_count_load <= 1'b1;
        dma_count_value <= 16'h0004;
        pulse('{enable_cmd: 1'b1, default: 1'b0});
        dma_count_load <= 1'b0;
        mem_error <= 1'b1;
        dma_enable <= 1'b1;
        cyc(3);
        mem_error <= 1'b0;
        cyc(20);
        #1;
        check({dma_stalled, transmit_empty_flag, busy, mem_ready},
              4'b1100);
        cyc(1);
        dma_enable <= 1'b0;
        cyc(2);
        pulse('{disable_cmd: 1'b1, default: 1'b0});
        pulse('{enable_cmd: 1'b1, default: 1'b0});
        dma_enable <= 1'b1;
        cyc(2);
        #1;
        check(dma_stalled, 1'b0);
        wait_on(2, 1'b1);
        check(dma_remaining, 16'h0000);
        cyc(1);
        mem_valid <= 1'b0;
        dma_enable <= 1'b0;
        // another master selecting us with fault detection on
        cfg.fault_detect_disable <= 1'b0;
        i_spidf_peer.send(word);
        cyc(2);
        #1;
        check({mode_fault, enabled}, 2'b10);
        results();
    end
endmodule : test_spi_port_with_dma_feed
